// [pkg/lam_grader_defines.vh]
`ifndef LAM_GRADER_DEFINES_VH
`define LAM_GRADER_DEFINES_VH

`define SLOT_COUNT 24
`define SLOT_W 5
`define QUEUE_DEPTH 16
`define QUEUE_AW 4

`define FN_READ_MASK 5'h00
`define FN_READ_ID 5'h06
`define FN_LOAD_MASK 5'h10
`define FN_CLEAR_QUEUE 5'h18
`define FN_ARM 5'h1a
`define SUBADDR_CMD 4'h0

`define MASK_RESET 24'h000000
`define MODULE_ID_VALUE 24'h0000a5

`define CLK_PERIOD_NS 100
`define DEMAND_HOLD_NS 2000
`define DEMAND_GAP_NS 200
`define DEMAND_HOLD_CYCLES ((`DEMAND_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEMAND_GAP_CYCLES ((`DEMAND_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W 8

`define ST_IDLE 2'h0
`define ST_HOLD 2'h1
`define ST_GAP 2'h2

`endif

// [logic/slot_queue.v]
`timescale 1ns/100ps
`default_nettype none
`include "lam_grader_defines.vh"

module slot_queue (
  input wire ref_clk,
  input wire rst_n,
  input wire flush,
  input wire push,
  input wire [`SLOT_W-1:0] push_data,
  input wire pop,
  output wire [`SLOT_W-1:0] head_data,
  output wire full,
  output wire empty
);
  reg [`SLOT_W-1:0] store [0:`QUEUE_DEPTH-1];
  reg [`QUEUE_AW-1:0] wr_ptr_reg;
  reg [`QUEUE_AW-1:0] rd_ptr_reg;
  reg [`QUEUE_AW:0] count_reg;
  wire do_push;
  wire do_pop;

  // push is refused when full, pop when empty, so the count never wraps
  assign full = (count_reg == `QUEUE_DEPTH);
  assign empty = (count_reg == {(`QUEUE_AW+1){1'b0}});
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign head_data = store[rd_ptr_reg];

  always @(posedge ref_clk) begin
    if (do_push) begin
      store[wr_ptr_reg] <= push_data;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n || flush) begin
      wr_ptr_reg <= {`QUEUE_AW{1'b0}};
      rd_ptr_reg <= {`QUEUE_AW{1'b0}};
      count_reg <= {(`QUEUE_AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// [logic/lam_priority_demand_encoder.v]
`timescale 1ns/100ps
`default_nettype none
`include "lam_grader_defines.vh"

module lam_priority_demand_encoder (
  input wire ref_clk,
  input wire rst_n,
  input wire station_sel,
  input wire [4:0] func_code,
  input wire [3:0] sub_addr,
  input wire strobe_s1,
  input wire dataway_clear,
  input wire [`SLOT_COUNT-1:0] write_data,
  input wire [`SLOT_COUNT-1:0] lam_in,
  input wire enable_demands,
  output reg [`SLOT_COUNT-1:0] read_data,
  output reg q_resp,
  output reg x_resp,
  output reg [`SLOT_W-1:0] grader_lines,
  output reg demand_initiate,
  output reg demand_hold_strobe
);
  // arbitrary identity value, not tied to any real part
  parameter [`SLOT_COUNT-1:0] MODULE_ID = `MODULE_ID_VALUE;

  // the cycle counts are worked out as integers, then cut to the timer width on purpose
  localparam integer HOLD_COUNT = `DEMAND_HOLD_CYCLES;
  localparam integer GAP_COUNT = `DEMAND_GAP_CYCLES;
  localparam [`TIMER_W-1:0] HOLD_CYCLES = HOLD_COUNT[`TIMER_W-1:0];
  localparam [`TIMER_W-1:0] GAP_CYCLES = GAP_COUNT[`TIMER_W-1:0];

  reg [`SLOT_COUNT-1:0] request_mask_reg;
  reg [`SLOT_COUNT-1:0] serviced_reg;
  reg armed_reg;
  reg [1:0] state_reg;
  reg [`TIMER_W-1:0] timer_reg;

  wire cmd_addr_ok;
  wire cmd_read_mask;
  wire cmd_read_id;
  wire cmd_load_mask;
  wire cmd_clear;
  wire cmd_arm;
  wire cmd_known;
  wire strobe_hit;
  wire do_arm;
  wire do_flush;

  wire [`SLOT_COUNT-1:0] pending;
  reg [`SLOT_W-1:0] pick_slot;
  reg [`SLOT_COUNT-1:0] pick_onehot;
  integer i;

  wire q_full;
  wire q_empty;
  wire [`SLOT_W-1:0] q_head;
  wire q_push;
  wire q_pop;

  // command decode; actions fire only on the S1 strobe while addressed, except the flush from dataway_clear
  assign cmd_addr_ok = station_sel & (sub_addr == `SUBADDR_CMD);
  assign cmd_read_mask = cmd_addr_ok & (func_code == `FN_READ_MASK);
  assign cmd_read_id = cmd_addr_ok & (func_code == `FN_READ_ID);
  assign cmd_load_mask = cmd_addr_ok & (func_code == `FN_LOAD_MASK);
  assign cmd_clear = cmd_addr_ok & (func_code == `FN_CLEAR_QUEUE);
  assign cmd_arm = cmd_addr_ok & (func_code == `FN_ARM);
  assign cmd_known = cmd_read_mask | cmd_read_id | cmd_load_mask | cmd_clear | cmd_arm;
  assign strobe_hit = strobe_s1 & station_sel;
  assign do_arm = strobe_hit & cmd_arm;
  assign do_flush = (strobe_hit & cmd_clear) | dataway_clear;

  // masked, armed, not yet serviced requests
  assign pending = lam_in & request_mask_reg & ~serviced_reg & {`SLOT_COUNT{armed_reg}};

  // lowest slot wins; the loop runs downward so the last hit is the lowest
  always @* begin
    pick_slot = {`SLOT_W{1'b0}};
    pick_onehot = {`SLOT_COUNT{1'b0}};
    for (i = `SLOT_COUNT - 1; i >= 0; i = i - 1) begin
      if (pending[i]) begin
        pick_slot = i[`SLOT_W-1:0] + 1'b1;
        pick_onehot = {`SLOT_COUNT{1'b0}};
        pick_onehot[i] = 1'b1;
      end
    end
  end

  // one slot per cycle; a full queue leaves the source pending, and the
  // arm cycle pushes nothing so the rearm is never undone by a stale mark
  assign q_push = (|pending) & ~q_full & ~do_arm & ~do_flush;
  // no pop while the queue is being cleared, so a flushed slot never becomes a demand
  assign q_pop = (state_reg == `ST_IDLE) & ~q_empty & enable_demands & ~do_flush;

  slot_queue u_queue (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .flush(do_flush),
    .push(q_push),
    .push_data(pick_slot),
    .pop(q_pop),
    .head_data(q_head),
    .full(q_full),
    .empty(q_empty)
  );

  // mask register, arm state and serviced marks
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      request_mask_reg <= `MASK_RESET;
      armed_reg <= 1'b0;
      serviced_reg <= {`SLOT_COUNT{1'b0}};
    end else begin
      if (strobe_hit && cmd_load_mask) begin
        request_mask_reg <= write_data;
      end
      if (do_arm) begin
        armed_reg <= 1'b1;
        serviced_reg <= {`SLOT_COUNT{1'b0}};
      end else if (q_push) begin
        serviced_reg <= serviced_reg | pick_onehot;
      end
    end
  end

  // dataway answers: registered, following the addressed command
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      read_data <= {`SLOT_COUNT{1'b0}};
      q_resp <= 1'b0;
      x_resp <= 1'b0;
    end else begin
      q_resp <= cmd_known;
      x_resp <= cmd_known;
      if (cmd_read_mask) begin
        read_data <= request_mask_reg;
      end else if (cmd_read_id) begin
        read_data <= MODULE_ID;
      end else begin
        read_data <= {`SLOT_COUNT{1'b0}};
      end
    end
  end

  // demand sequencer: the strobe is held for a fixed time, never left hung,
  // so a controller timeout would only fire on a genuine fault
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= `ST_IDLE;
      timer_reg <= {`TIMER_W{1'b0}};
      grader_lines <= {`SLOT_W{1'b0}};
      demand_initiate <= 1'b0;
      demand_hold_strobe <= 1'b0;
    end else begin
      case (state_reg)
        `ST_IDLE: begin
          if (q_pop) begin
            grader_lines <= q_head;
            demand_initiate <= 1'b1;
            demand_hold_strobe <= 1'b1;
            timer_reg <= HOLD_CYCLES - 1'b1;
            state_reg <= `ST_HOLD;
          end
        end
        `ST_HOLD: begin
          if (!enable_demands) begin
            demand_initiate <= 1'b0;
          end
          if (timer_reg == {`TIMER_W{1'b0}}) begin
            demand_initiate <= 1'b0;
            demand_hold_strobe <= 1'b0;
            timer_reg <= GAP_CYCLES - 1'b1;
            state_reg <= `ST_GAP;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        `ST_GAP: begin
          if (timer_reg == {`TIMER_W{1'b0}}) begin
            grader_lines <= {`SLOT_W{1'b0}};
            state_reg <= `ST_IDLE;
          end else begin
            timer_reg <= timer_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= `ST_IDLE;
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// [testbench/lam_grader_checker.sv]
`timescale 1ns/100ps
`default_nettype none
`include "lam_grader_defines.vh"
module lam_grader_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic station_sel,
  input wire logic [4:0] func_code,
  input wire logic [3:0] sub_addr,
  input wire logic strobe_s1,
  input wire logic [23:0] write_data,
  input wire logic enable_demands,
  input wire logic [23:0] read_data,
  input wire logic q_resp,
  input wire logic x_resp,
  input wire logic [4:0] grader_lines,
  input wire logic demand_initiate,
  input wire logic demand_hold_strobe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire cmd = station_sel && sub_addr == `SUBADDR_CMD;
  logic [23:0] mask_copy;
  always @(posedge ref_clk) begin
    if (!rst_n) mask_copy <= 24'h000000;
    else if (cmd && strobe_s1 && func_code == `FN_LOAD_MASK) mask_copy <= write_data;
  end
  a_load_answers: assert property (cmd && func_code == `FN_LOAD_MASK |=> q_resp && x_resp)
    else $error("load mask not answered");
  a_clear_answers: assert property (cmd && func_code == `FN_CLEAR_QUEUE |=> q_resp && x_resp)
    else $error("clear queue not answered");
  a_arm_answers: assert property (cmd && func_code == `FN_ARM |=> q_resp && x_resp)
    else $error("arm not answered");
  a_bad_addr_refused: assert property (station_sel && sub_addr != 4'h0 |=> !q_resp && !x_resp && read_data == 24'h0)
    else $error("nonzero subaddress answered");
  a_mask_readback: assert property (cmd && func_code == `FN_READ_MASK |=> read_data == $past(mask_copy))
    else $error("mask readback wrong");
  a_initiate_enabled: assert property (demand_initiate |-> demand_hold_strobe && $past(enable_demands))
    else $error("initiate without enable");
  a_no_start_disabled: assert property (!enable_demands && !demand_hold_strobe |=> !demand_hold_strobe)
    else $error("demand started while disabled");
  a_hold_length: assert property ($rose(demand_hold_strobe) |-> ##19 demand_hold_strobe ##1 !demand_hold_strobe)
    else $error("hold strobe length wrong");
  a_gap_kept: assert property ($fell(demand_hold_strobe) |-> !demand_hold_strobe [*2])
    else $error("gap between demands too short");
  a_slot_steady: assert property (demand_hold_strobe |-> grader_lines >= 5'h01 && grader_lines <= 5'h18 &&
    (!$past(demand_hold_strobe) || $stable(grader_lines)))
    else $error("slot number bad during hold");
  a_initiate_starts: assert property ($rose(demand_hold_strobe) |-> demand_initiate)
    else $error("demand started without initiate");
endmodule
`default_nettype wire

// [testbench/demand_controller_model.sv]
`timescale 1ns/100ps
`default_nettype none
module demand_controller_model (
  input wire logic ref_clk,
  input wire logic want_demands,
  input wire logic [4:0] grader_lines,
  input wire logic demand_hold_strobe,
  input wire logic demand_initiate,
  output wire logic enable_demands
);
  logic [4:0] slots [0:31];
  int cnt = 0;
  logic seen = 1'b0;
  assign enable_demands = want_demands;
  // no demand timeout: a long hold is never aborted
  always @(posedge ref_clk) begin
    seen <= demand_hold_strobe;
    // a message only counts when initiate comes with the strobe
    if (demand_hold_strobe && demand_initiate && !seen) begin
      slots[cnt] <= grader_lines;
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// [testbench/lam_priority_demand_encoder_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "lam_grader_defines.vh"
module lam_priority_demand_encoder_tb;
  logic ref_clk = 1'b0, rst_n = 1'b0, station_sel = 1'b0, strobe_s1 = 1'b0, dataway_clear = 1'b0, want = 1'b0;
  logic [4:0] func_code = 5'h00;
  logic [3:0] sub_addr = 4'h0;
  logic [23:0] write_data = 24'h0, lam_in = 24'h0;
  wire [23:0] read_data;
  wire q_resp, x_resp, demand_initiate, demand_hold_strobe, enable_demands;
  wire [4:0] grader_lines;
  int n_errors = 0, checks = 0, cycles = 0;
  logic [23:0] rd = 24'h0;
  lam_priority_demand_encoder dut (.ref_clk(ref_clk), .rst_n(rst_n), .station_sel(station_sel),
    .func_code(func_code), .sub_addr(sub_addr), .strobe_s1(strobe_s1), .dataway_clear(dataway_clear),
    .write_data(write_data), .lam_in(lam_in), .enable_demands(enable_demands), .read_data(read_data),
    .q_resp(q_resp), .x_resp(x_resp), .grader_lines(grader_lines), .demand_initiate(demand_initiate),
    .demand_hold_strobe(demand_hold_strobe));
  demand_controller_model far (.ref_clk(ref_clk), .want_demands(want), .grader_lines(grader_lines),
    .demand_hold_strobe(demand_hold_strobe), .demand_initiate(demand_initiate), .enable_demands(enable_demands));
  initial forever #50 ref_clk = ~ref_clk;
  // the full-queue run needs about 530 cycles, the whole test about 800
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task cmd(input logic [4:0] f, input logic [3:0] a, input logic [23:0] w, input logic qx);
    @(posedge ref_clk);
    station_sel <= 1'b1;
    func_code <= f;
    sub_addr <= a;
    write_data <= w;
    strobe_s1 <= 1'b1;
    @(posedge ref_clk);
    station_sel <= 1'b0;
    strobe_s1 <= 1'b0;
    // answers stand one cycle: take them mid-cycle, hand back on a rising edge
    @(negedge ref_clk);
    rd = read_data;
    chk("q x", {22'h0, qx, qx}, {22'h0, q_resp, x_resp});
    @(posedge ref_clk);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    cmd(`FN_READ_MASK, 4'h0, 24'h0, 1'b1);
    chk("mask reset", 24'h0, rd);
    cmd(`FN_READ_ID, 4'h0, 24'h0, 1'b1);
    chk("module id", `MODULE_ID_VALUE, rd);
    cmd(`FN_LOAD_MASK, 4'h0, 24'hfffffb, 1'b1);
    cmd(`FN_LOAD_MASK, 4'h1, 24'h000001, 1'b0);
    cmd(`FN_READ_MASK, 4'h0, 24'h0, 1'b1);
    chk("mask", 24'hfffffb, rd);
    $display("test registers done");
    // all sources up before arming, so the queue fills and 7 sources stay pending while demands are off
    lam_in <= 24'hffffff;
    cmd(`FN_CLEAR_QUEUE, 4'h0, 24'h0, 1'b1);
    cmd(`FN_ARM, 4'h0, 24'h0, 1'b1);
    repeat (40) @(posedge ref_clk);
    chk("count disabled", 24'h0, 24'(far.cnt));
    want <= 1'b1;
    repeat (640) @(posedge ref_clk);
    chk("count", 24'h17, 24'(far.cnt));
    for (int i = 0; i < 23; i++) chk("slot", 24'(i < 2 ? i + 1 : i + 2), {19'h0, far.slots[i]});
    $display("test priority done");
    want <= 1'b0;
    lam_in <= 24'h0;
    cmd(`FN_ARM, 4'h0, 24'h0, 1'b1);
    lam_in <= 24'h000001;
    repeat (4) @(posedge ref_clk);
    cmd(`FN_CLEAR_QUEUE, 4'h0, 24'h0, 1'b1);
    lam_in <= 24'h000011;
    repeat (4) @(posedge ref_clk);
    dataway_clear <= 1'b1;
    @(posedge ref_clk);
    dataway_clear <= 1'b0;
    lam_in <= 24'h0;
    want <= 1'b1;
    repeat (40) @(posedge ref_clk);
    chk("count cleared", 24'h17, 24'(far.cnt));
    lam_in <= 24'h000002;
    repeat (40) @(posedge ref_clk);
    chk("count new", 24'h18, 24'(far.cnt));
    chk("slot new", 24'h2, {19'h0, far.slots[23]});
    $display("test clears done");
    tally_and_finish;
  end
endmodule
bind lam_priority_demand_encoder lam_grader_checker chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
  .station_sel(station_sel), .func_code(func_code), .sub_addr(sub_addr), .strobe_s1(strobe_s1),
  .write_data(write_data), .enable_demands(enable_demands), .read_data(read_data), .q_resp(q_resp),
  .x_resp(x_resp), .grader_lines(grader_lines), .demand_initiate(demand_initiate),
  .demand_hold_strobe(demand_hold_strobe));
`default_nettype wire
